/* File: vector_map_pkg.sv */
// Constants and carrier types for the reset and interrupt vector mapper.
// Assumes word-addressed program memory and one core clock for all users.
package vector_map_pkg;

   // Table shape: 32 entries, two words apart.
   localparam int NUM_VECTORS = 32;
   localparam int VEC_SPACING = 2;
   localparam int ADDR_W      = 16;
   localparam int NUM_W       = 5;
   localparam int SYNC_STAGES = 2;

   typedef logic [ADDR_W-1:0] vec_addr_t;
   typedef logic [NUM_W-1:0]  vec_num_t;

   // Reset entry and the named interrupt entries (word addresses).
   localparam vec_addr_t RESET_ADDR              = 16'h0000;
   localparam vec_addr_t STAGE_CTRL2_CAPTURE_VEC = 16'h0002;
   localparam vec_addr_t STAGE_CTRL2_CYCLE_END_VEC = 16'h0004;
   localparam vec_addr_t STAGE_CTRL1_CAPTURE_VEC = 16'h0006;
   localparam vec_addr_t STAGE_CTRL1_CYCLE_END_VEC = 16'h0008;
   localparam vec_addr_t STAGE_CTRL0_CAPTURE_VEC = 16'h000a;
   localparam vec_addr_t STAGE_CTRL0_CYCLE_END_VEC = 16'h000c;
   localparam vec_addr_t COMPARATOR0_VEC         = 16'h000e;
   localparam vec_addr_t COMPARATOR1_VEC         = 16'h0010;
   localparam vec_addr_t COMPARATOR2_VEC         = 16'h0012;
   localparam vec_addr_t EXT_REQUEST0_VEC        = 16'h0014;
   localparam vec_addr_t TIMER16_CAPTURE_VEC     = 16'h0016;
   localparam vec_addr_t TIMER16_COMPARE_A_VEC   = 16'h0018;
   localparam vec_addr_t TIMER16_COMPARE_B_VEC   = 16'h001a;
   localparam vec_addr_t SPARE_SLOT15_VEC        = 16'h001c;
   localparam vec_addr_t TIMER16_OVERFLOW_VEC    = 16'h001e;
   localparam vec_addr_t TIMER8_COMPARE_A_VEC    = 16'h0020;
   localparam vec_addr_t TIMER8_OVERFLOW_VEC     = 16'h0022;
   localparam vec_addr_t CONVERTER_DONE_VEC      = 16'h0024;
   localparam vec_addr_t EXT_REQUEST1_VEC        = 16'h0026;
   localparam vec_addr_t SERIAL_PERIPH_DONE_VEC  = 16'h0028;
   localparam vec_addr_t SERIAL_RX_DONE_VEC      = 16'h002a;
   localparam vec_addr_t SERIAL_TX_EMPTY_VEC     = 16'h002c;
   localparam vec_addr_t SERIAL_TX_DONE_VEC      = 16'h002e;
   localparam vec_addr_t EXT_REQUEST2_VEC        = 16'h0030;
   localparam vec_addr_t WATCHDOG_VEC            = 16'h0032;
   localparam vec_addr_t NV_DATA_READY_VEC       = 16'h0034;
   localparam vec_addr_t TIMER8_COMPARE_B_VEC    = 16'h0036;
   localparam vec_addr_t EXT_REQUEST3_VEC        = 16'h0038;
   localparam vec_addr_t SPARE_SLOT30_VEC        = 16'h003a;
   localparam vec_addr_t SPARE_SLOT31_VEC        = 16'h003c;
   localparam vec_addr_t SELF_PROGRAM_READY_VEC  = 16'h003e;

   // Index i holds vector number i+1.
   localparam vec_addr_t VEC_TABLE [NUM_VECTORS] = '{
      RESET_ADDR, STAGE_CTRL2_CAPTURE_VEC, STAGE_CTRL2_CYCLE_END_VEC,
      STAGE_CTRL1_CAPTURE_VEC, STAGE_CTRL1_CYCLE_END_VEC,
      STAGE_CTRL0_CAPTURE_VEC, STAGE_CTRL0_CYCLE_END_VEC,
      COMPARATOR0_VEC, COMPARATOR1_VEC, COMPARATOR2_VEC, EXT_REQUEST0_VEC,
      TIMER16_CAPTURE_VEC, TIMER16_COMPARE_A_VEC, TIMER16_COMPARE_B_VEC,
      SPARE_SLOT15_VEC, TIMER16_OVERFLOW_VEC, TIMER8_COMPARE_A_VEC,
      TIMER8_OVERFLOW_VEC, CONVERTER_DONE_VEC, EXT_REQUEST1_VEC,
      SERIAL_PERIPH_DONE_VEC, SERIAL_RX_DONE_VEC, SERIAL_TX_EMPTY_VEC,
      SERIAL_TX_DONE_VEC, EXT_REQUEST2_VEC, WATCHDOG_VEC, NV_DATA_READY_VEC,
      TIMER8_COMPARE_B_VEC, EXT_REQUEST3_VEC, SPARE_SLOT30_VEC,
      SPARE_SLOT31_VEC, SELF_PROGRAM_READY_VEC};

   // Bit 0 is the reset entry; bits 14, 29 and 30 are unassigned slots.
   localparam logic [NUM_VECTORS-1:0] IRQ_ASSIGNED = 32'h9fff_bffe;

   // Reset causes, one bit each.
   localparam int CAUSE_W = 5;
   localparam int CAUSE_PIN = 0;
   localparam int CAUSE_POWER_ON = 1;
   localparam int CAUSE_BROWN_OUT = 2;
   localparam int CAUSE_WATCHDOG = 3;
   localparam int CAUSE_EMULATOR = 4;

   // What the core is offered.
   typedef struct packed {
      logic      is_reset;
      vec_num_t  num;
      vec_addr_t addr;
   } vec_offer_t;

endpackage

/* File: reset_interrupt_vector_mapper.sv */
// Reset and interrupt vector mapper: turns a reset cause or the best
// pending interrupt into the program word address the core fetches next.
// Assumes requests, enables and handshake come from the core clock domain;
// the fuse strap and boot section start come from pins.
// The straps must hold still while RSTN is high; no handshake guards them.
//
// How it works
// - Any reset cause offers vector one at word address 0x0000.
// - Thirty-two entries two words apart; last, self-program ready, at 0x003E.
// - Stage controllers two, one, zero: capture then cycle end, 0x0002..0x000C.
// - Comparators zero to two at 0x000E..0x0012; external request zero 0x0014.
// - Sixteen-bit timer vectors 0x0016..0x001A, overflow 0x001E; 0x001C unused.
// - Eight-bit timer compare A 0x0020, overflow 0x0022, compare B 0x0036.
// - Converter 0x0024, request one 0x0026, serial vectors 0x0028..0x002E.
// - Request two 0x0030, watchdog 0x0032, nv ready 0x0034, request three 0x0038.
// - Programmed boot fuse moves the reset entry to the boot reset address.
// - With table select set, interrupt addresses add the boot section start.
// - Fuse steers only reset placement, table select only interrupt placement.

module reset_interrupt_vector_mapper
#(
   parameter int BOOT_W = vector_map_pkg::ADDR_W
)
(
   // Clock and reset.
   input  wire logic                                 CLK,
   input  wire logic                                 RSTN,
   // Reset causes, one-cycle pulses from the reset logic.
   input  wire logic [vector_map_pkg::CAUSE_W-1:0]     RESET_CAUSE,
   // Straps from pins.
   input  wire logic                                 BOOT_RESET_FUSE,
   input  wire logic [BOOT_W-1:0]                    BOOT_START,
   // Core side controls.
   input  wire logic                                 VECTOR_TABLE_SELECT,
   input  wire logic                                 GLOBAL_IRQ_EN,
   // Peripheral requests and their enables; bit i is vector i+1.
   input  wire logic [vector_map_pkg::NUM_VECTORS-1:0] IRQ_PENDING,
   input  wire logic [vector_map_pkg::NUM_VECTORS-1:0] IRQ_ENABLE,
   // Offer to the core.
   output logic                                      VEC_VALID,
   input  wire logic                                 VEC_TAKEN,
   output vector_map_pkg::vec_offer_t                VEC_OFFER,
   // Acknowledge back to the request sources.
   output logic [vector_map_pkg::NUM_VECTORS-1:0]      IRQ_ACK,
   // Status.
   output logic [vector_map_pkg::CAUSE_W-1:0]          LAST_RESET_CAUSE
);

   typedef enum logic [1:0] {ST_SETTLE, ST_IDLE, ST_OFFER} state_t;

   // Strap synchronisers and the start-up wait.
   logic [vector_map_pkg::SYNC_STAGES-1:0]    fuse_sync_q;
   logic [BOOT_W-1:0]                         boot_meta_q;
   logic [BOOT_W-1:0]                         boot_start_q;
   logic [1:0]                                settle_q;
   logic                                      settle_done;
   logic                                      fuse_prog;
   vector_map_pkg::vec_addr_t                 boot_addr;

   // Reset bookkeeping.
   logic                                      cause_seen;
   logic                                      reset_pend_q;
   logic [vector_map_pkg::CAUSE_W-1:0]        cause_q;
   vector_map_pkg::vec_addr_t                 reset_addr;

   // Request selection and placement.
   logic [vector_map_pkg::NUM_VECTORS-1:0]    live_req;
   logic                                      pick_any;
   vector_map_pkg::vec_num_t                  pick_idx;
   vector_map_pkg::vec_addr_t                 irq_base;
   vector_map_pkg::vec_addr_t                 irq_addr;

   // Offer handshake and acknowledge.
   state_t                                    state_q;
   vector_map_pkg::vec_offer_t                offer_q;
   vector_map_pkg::vec_offer_t                offer_d;
   logic                                      start_offer;
   logic                                      replace_offer;
   logic                                      take;
   logic [vector_map_pkg::NUM_VECTORS-1:0]    ack_q;

   // Pin straps pass two flip-flops before anything reads them.
   // The boot start word is synchronised bit by bit, so it must not move while running.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         fuse_sync_q  <= '0;
         boot_meta_q  <= '0;
         boot_start_q <= '0;
      end
      else
      begin
         fuse_sync_q  <= {fuse_sync_q[0], BOOT_RESET_FUSE};
         boot_meta_q  <= BOOT_START;
         boot_start_q <= boot_meta_q;
      end
   end

   assign fuse_prog = fuse_sync_q[vector_map_pkg::SYNC_STAGES-1];
   assign boot_addr = vector_map_pkg::ADDR_W'(boot_start_q);

   // Wait for the straps to settle so the first reset entry sees the real fuse.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         settle_q <= '0;
      end
      else if (state_q == ST_SETTLE)
      begin
         settle_q <= settle_q + 2'h1;
      end
   end

   // The settle wait ends once both synchroniser stages hold pin values.
   assign settle_done = (settle_q == 2'(vector_map_pkg::SYNC_STAGES));

   // The core's take counts only while an offer stands; at other times the
   // input is ignored.
   assign take = (state_q == ST_OFFER) && VEC_TAKEN;

   // Any cause bit asks for the reset entry; the bits differ only in what is
   // recorded for software.
   assign cause_seen = |RESET_CAUSE;

   // A reset entry is owed after release and after every reset cause.
   // A new cause in the cycle the entry is taken keeps the flag set.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         reset_pend_q <= 1'b1;
      end
      else if (cause_seen)
      begin
         reset_pend_q <= 1'b1;
      end
      else if (take && offer_q.is_reset)
      begin
         reset_pend_q <= 1'b0;
      end
   end

   // Remember which cause asked last, for software to inspect.
   // Only RSTN clears it, so it outlives the reset entry that it asked for.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cause_q <= '0;
      end
      else if (cause_seen)
      begin
         cause_q <= RESET_CAUSE;
      end
   end

   // Only enabled, assigned sources compete; spare slots never dispatch, so a
   // spare request raised by mistake simply stays pending.
   assign live_req = IRQ_PENDING & IRQ_ENABLE & vector_map_pkg::IRQ_ASSIGNED;

   // Lowest vector number wins: scan from the top so the last hit is lowest.
   // Index zero is the reset entry and is left out of the scan.
   always_comb
   begin
      pick_any = 1'b0;
      pick_idx = '0;
      for (int i = vector_map_pkg::NUM_VECTORS - 1; i > 0; i--)
      begin
         if (live_req[i])
         begin
            pick_any = 1'b1;
            pick_idx = vector_map_pkg::NUM_W'(i);
         end
      end
   end

   // Reset placement follows the fuse alone: programmed sends the core to the
   // boot section start, unprogrammed to word zero.
   assign reset_addr = fuse_prog ? boot_addr : vector_map_pkg::RESET_ADDR;

   // Interrupt placement follows the select bit alone; the table keeps its
   // two-word spacing and only its base moves.
   assign irq_base = VECTOR_TABLE_SELECT ? boot_addr : '0;
   assign irq_addr = vector_map_pkg::VEC_TABLE[pick_idx]
                     + irq_base;

   // Leave idle when a reset entry is owed, or when interrupts are globally
   // enabled and a live request waits.
   assign start_offer = (state_q == ST_IDLE)
                        && (reset_pend_q || (GLOBAL_IRQ_EN && pick_any));

   // A reset cause during an interrupt offer replaces it, since reset must
   // not wait behind a handler.
   assign replace_offer = (state_q == ST_OFFER) && !offer_q.is_reset && reset_pend_q;

   // Build the offer; reset beats any interrupt, and the offer keeps its
   // value when there is nothing new to offer.
   always_comb
   begin
      offer_d = offer_q;
      if (reset_pend_q)
      begin
         offer_d.is_reset = 1'b1;
         offer_d.num      = '0;
         offer_d.addr     = reset_addr;
      end
      else if (pick_any)
      begin
         offer_d.is_reset = 1'b0;
         offer_d.num      = pick_idx;
         offer_d.addr     = irq_addr;
      end
   end

   // Offer state machine: settle, then wait for work, then keep the offer
   // standing until the core takes it.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state_q <= ST_SETTLE;
      end
      else
      begin
         case (state_q)
            ST_SETTLE:
            begin
               // No offer until the fuse and boot start are trustworthy.
               if (settle_done)
               begin
                  state_q <= ST_IDLE;
               end
            end
            ST_IDLE:
            begin
               // Reset entry first, interrupts only while globally enabled.
               if (start_offer)
               begin
                  state_q <= ST_OFFER;
               end
            end
            ST_OFFER:
            begin
               // The offer stands until the core takes it.
               if (VEC_TAKEN)
               begin
                  state_q <= ST_IDLE;
               end
            end
            default:
            begin
               state_q <= ST_SETTLE;
            end
         endcase
      end
   end

   // Latch the offer on leaving idle; a reset cause during an interrupt
   // offer replaces it, since reset must not wait behind a handler.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         offer_q <= '0;
      end
      else if (start_offer)
      begin
         offer_q <= offer_d;
      end
      else if (replace_offer)
      begin
         offer_q <= offer_d;
      end
   end

   // One-cycle acknowledge to the source whose vector was taken, so it can
   // clear its flag in hardware.
   // A reset entry is never acknowledged: no source flag stands behind it.
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ack_q <= '0;
      end
      else
      begin
         ack_q <= '0;
         if (take && !offer_q.is_reset)
         begin
            ack_q[offer_q.num] <= 1'b1;
         end
      end
   end

   // Outputs. Valid comes from the state register and the data outputs from
   // flip-flops, so the core never sees a glitching address.
   assign VEC_VALID        = (state_q == ST_OFFER);
   assign VEC_OFFER        = offer_q;
   assign IRQ_ACK          = ack_q;
   assign LAST_RESET_CAUSE = cause_q;

endmodule // reset_interrupt_vector_mapper

/* File: reset_interrupt_vector_mapper_assertions.sv */
// Checker for the vector mapper: offer addresses, dispatch order, acknowledges.
// Assumes straps change only in reset and table select only while idle.
module reset_interrupt_vector_mapper_assertions
#(
   parameter int BOOT_W = 16
)
(
   // Watched ports.
   input wire logic                              CLK,
   input wire logic                              RSTN,
   input wire logic [vector_map_pkg::CAUSE_W-1:0] RESET_CAUSE,
   input wire logic                              BOOT_RESET_FUSE,
   input wire logic [BOOT_W-1:0]                 BOOT_START,
   input wire logic                              VECTOR_TABLE_SELECT,
   input wire logic [31:0]                       IRQ_PENDING,
   input wire logic [31:0]                       IRQ_ENABLE,
   input wire logic                              VEC_VALID,
   input wire logic                              VEC_TAKEN,
   input wire vector_map_pkg::vec_offer_t        VEC_OFFER,
   input wire logic [31:0]                       IRQ_ACK,
   input wire logic [vector_map_pkg::CAUSE_W-1:0] LAST_RESET_CAUSE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   // Each assertion ties an offer, acknowledge or recorded cause to the inputs that caused it.
   chk_reset_addr: assert property (
      VEC_VALID && VEC_OFFER.is_reset |->
      VEC_OFFER.addr == (BOOT_RESET_FUSE ? 16'(BOOT_START) : 16'h0000))
      else $error("reset entry address wrong");
   chk_irq_addr: assert property (
      $rose(VEC_VALID) && !VEC_OFFER.is_reset |-> VEC_OFFER.addr ==
      16'({VEC_OFFER.num, 1'b0}) + ($past(VECTOR_TABLE_SELECT) ? 16'(BOOT_START) : 16'h0000))
      else $error("interrupt entry address wrong");
   chk_lowest_first: assert property (
      $rose(VEC_VALID) && !VEC_OFFER.is_reset |->
      ($past(IRQ_PENDING) & $past(IRQ_ENABLE) & vector_map_pkg::IRQ_ASSIGNED &
      ((32'h1 << VEC_OFFER.num) - 32'h1)) == 32'h0)
      else $error("lower pending vector skipped");
   chk_spare_slot: assert property (
      VEC_VALID && !VEC_OFFER.is_reset |-> vector_map_pkg::IRQ_ASSIGNED[VEC_OFFER.num])
      else $error("unassigned slot dispatched");
   chk_offer_stands: assert property (
      VEC_VALID && !VEC_TAKEN && RESET_CAUSE == 5'h00 && $past(RESET_CAUSE) == 5'h00
      |=> VEC_VALID && $stable(VEC_OFFER))
      else $error("offer changed before take");
   chk_ack_pulse: assert property (
      VEC_VALID && VEC_TAKEN && !VEC_OFFER.is_reset |=>
      IRQ_ACK == (32'h1 << $past(VEC_OFFER.num)) ##1 IRQ_ACK == 32'h0)
      else $error("acknowledge wrong");
   chk_reset_no_ack: assert property (
      VEC_VALID && VEC_TAKEN && VEC_OFFER.is_reset |=> IRQ_ACK == 32'h0 && !VEC_VALID)
      else $error("reset entry acknowledged");
   chk_take_drops: assert property (
      VEC_VALID && VEC_TAKEN |=> !VEC_VALID)
      else $error("offer stayed after take");
   chk_cause_kept: assert property (
      RESET_CAUSE != 5'h00 |=> LAST_RESET_CAUSE == $past(RESET_CAUSE))
      else $error("reset cause not recorded");
   chk_reset_preempts: assert property (
      VEC_VALID && !VEC_TAKEN && !VEC_OFFER.is_reset && RESET_CAUSE != 5'h00 ##1 !VEC_TAKEN
      |=> VEC_VALID && VEC_OFFER.is_reset)
      else $error("reset did not replace a waiting interrupt offer");
endmodule // reset_interrupt_vector_mapper_assertions

/* File: core_fetch_model.sv */
// Core model: takes each offer after a chosen number of cycles.
// Assumes the mapper holds its offer until the take edge.
module core_fetch_model
(
   // Clock, reset, offer and pacing.
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       valid,
   input  wire logic [3:0] delay,
   output logic            taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q;

   // Moves at the falling edge only, so the take is held across the sampling edge.
   always @(negedge clk or negedge rstn)
   begin
      if (!rstn || !valid)
      begin
         taken  <= 1'b0;
         wait_q <= 4'h0;
      end
      else if (wait_q >= delay)
         taken <= 1'b1;
      else
         wait_q <= wait_q + 4'h1;
   end
endmodule // core_fetch_model

/* File: reset_interrupt_vector_mapper_tb.sv */
// Testbench for the vector mapper: drives causes, straps and requests.
// Assumes the core model takes every offer; inputs move at falling edges.
module reset_interrupt_vector_mapper_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                       CLK, RSTN, BOOT_RESET_FUSE, VECTOR_TABLE_SELECT;
   logic                       GLOBAL_IRQ_EN, VEC_VALID, VEC_TAKEN;
   logic [4:0]                 RESET_CAUSE, LAST_RESET_CAUSE;
   logic [15:0]                BOOT_START;
   logic [31:0]                IRQ_PENDING, IRQ_ENABLE, IRQ_ACK;
   logic [3:0]                 delay;
   vector_map_pkg::vec_offer_t VEC_OFFER;
   int                         error_cnt, compares;

   reset_interrupt_vector_mapper u_dut (.CLK(CLK), .RSTN(RSTN), .RESET_CAUSE(RESET_CAUSE),
      .BOOT_RESET_FUSE(BOOT_RESET_FUSE), .BOOT_START(BOOT_START),
      .VECTOR_TABLE_SELECT(VECTOR_TABLE_SELECT), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
      .IRQ_PENDING(IRQ_PENDING), .IRQ_ENABLE(IRQ_ENABLE), .VEC_VALID(VEC_VALID),
      .VEC_TAKEN(VEC_TAKEN), .VEC_OFFER(VEC_OFFER), .IRQ_ACK(IRQ_ACK),
      .LAST_RESET_CAUSE(LAST_RESET_CAUSE));
   core_fetch_model u_core (.clk(CLK), .rstn(RSTN), .valid(VEC_VALID), .delay(delay),
      .taken(VEC_TAKEN));

   // One mismatch line per failed compare.
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("compares %0d, error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Waits for an offer, checks it, waits for the take and checks the acknowledge.
   task automatic serve(logic rst, logic [4:0] num, logic [15:0] addr);
      int n;
      n = 0;
      while (VEC_VALID !== 1'b1 && n < 20)
      begin
         @(negedge CLK);
         n++;
      end
      check("valid", 32'h1, 32'(VEC_VALID));
      check("is_reset", 32'(rst), 32'(VEC_OFFER.is_reset));
      check("addr", 32'(addr), 32'(VEC_OFFER.addr));
      if (!rst)
         check("num", 32'(num), 32'(VEC_OFFER.num));
      n = 0;
      while (VEC_VALID === 1'b1 && n < 20)
      begin
         @(negedge CLK);
         n++;
      end
      check("valid", 32'h0, 32'(VEC_VALID));
      check("ack", rst ? 32'h0 : 32'h1 << num, IRQ_ACK);
      if (!rst)
         IRQ_PENDING[num] = 1'b0;
   endtask

   // No offer may appear for the given number of cycles.
   task automatic quiet(int cycles);
      repeat (cycles)
      begin
         @(negedge CLK);
         check("valid", 32'h0, 32'(VEC_VALID));
      end
   endtask

   task automatic do_reset(logic fuse);
      RSTN = 1'b0;
      BOOT_RESET_FUSE = fuse;
      repeat (2) @(negedge CLK);
      RSTN = 1'b1;
   endtask

   task automatic t_reset_causes;
      do_reset(1'b0);
      serve(1'b1, 5'h00, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         RESET_CAUSE = 5'h01 << i;
         @(negedge CLK);
         RESET_CAUSE = 5'h00;
         serve(1'b1, 5'h00, 16'h0000);
         check("last cause", 32'h1 << i, 32'(LAST_RESET_CAUSE));
      end
   endtask

   // Every interrupt slot once (1 to 31), spare ones must stay silent; the take delay varies.
   task automatic t_table;
      for (int k = 1; k < 32; k++)
      begin
         delay = 4'(k % 6);
         IRQ_PENDING[k] = 1'b1;
         if (k == 14 || k == 29 || k == 30)
         begin
            quiet(8);
            IRQ_PENDING[k] = 1'b0;
         end
         else
            serve(1'b0, 5'(k), 16'(2 * k));
      end
   endtask

   task automatic t_priority;
      GLOBAL_IRQ_EN = 1'b0;
      IRQ_ENABLE[7] = 1'b0;
      IRQ_PENDING = 32'h0200_0488;
      quiet(6);
      GLOBAL_IRQ_EN = 1'b1;
      serve(1'b0, 5'd3, 16'h0006);
      serve(1'b0, 5'd10, 16'h0014);
      serve(1'b0, 5'd25, 16'h0032);
      quiet(4);
      IRQ_ENABLE[7] = 1'b1;
      serve(1'b0, 5'd7, 16'h000e);
   endtask

   // A reset cause while an interrupt offer waits replaces it; the interrupt follows.
   task automatic t_preempt;
      delay = 4'h6;
      IRQ_PENDING[5] = 1'b1;
      @(negedge CLK);
      check("valid", 32'h1, 32'(VEC_VALID));
      check("is_reset", 32'h0, 32'(VEC_OFFER.is_reset));
      RESET_CAUSE = 5'h08;
      @(negedge CLK);
      RESET_CAUSE = 5'h00;
      @(negedge CLK);
      serve(1'b1, 5'h00, 16'h0000);
      serve(1'b0, 5'd5, 16'h000a);
   endtask

   task automatic t_boot;
      BOOT_START = 16'h0c00;
      do_reset(1'b1);
      serve(1'b1, 5'h00, 16'h0c00);
      IRQ_PENDING[1] = 1'b1;
      serve(1'b0, 5'd1, 16'h0002);
      VECTOR_TABLE_SELECT = 1'b1;
      IRQ_PENDING[31] = 1'b1;
      serve(1'b0, 5'd31, 16'h0c3e);
      IRQ_PENDING[10] = 1'b1;
      serve(1'b0, 5'd10, 16'h0c14);
      do_reset(1'b0);
      serve(1'b1, 5'h00, 16'h0000);
      IRQ_PENDING[3] = 1'b1;
      serve(1'b0, 5'd3, 16'h0c06);
   endtask

   // Free-running clock.
   initial
   begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   // Main sequence.
   initial
   begin
      {RSTN, BOOT_RESET_FUSE, VECTOR_TABLE_SELECT, GLOBAL_IRQ_EN} = 4'h0;
      {RESET_CAUSE, BOOT_START, IRQ_PENDING, delay} = '0;
      IRQ_ENABLE = 32'hffff_ffff;
      error_cnt = 0;
      compares = 0;
      @(negedge CLK);
      t_reset_causes();
      GLOBAL_IRQ_EN = 1'b1;
      t_table();
      t_priority();
      t_preempt();
      t_boot();
      end_sim();
   end

   // The run needs a few hundred cycles; far longer means a hang.
   initial
   begin
      #200us;
      error_cnt++;
      end_sim();
   end
endmodule // reset_interrupt_vector_mapper_tb

bind reset_interrupt_vector_mapper reset_interrupt_vector_mapper_assertions #(.BOOT_W(BOOT_W))
   u_chk (.CLK(CLK), .RSTN(RSTN), .RESET_CAUSE(RESET_CAUSE),
   .BOOT_RESET_FUSE(BOOT_RESET_FUSE), .BOOT_START(BOOT_START),
   .VECTOR_TABLE_SELECT(VECTOR_TABLE_SELECT), .IRQ_PENDING(IRQ_PENDING),
   .IRQ_ENABLE(IRQ_ENABLE), .VEC_VALID(VEC_VALID), .VEC_TAKEN(VEC_TAKEN),
   .VEC_OFFER(VEC_OFFER), .IRQ_ACK(IRQ_ACK), .LAST_RESET_CAUSE(LAST_RESET_CAUSE));
